// ---- hdl/adcr_top.sv ----
`timescale 1ns/1ps
// Operation
// - a 16-bit setup register holds mode, input pair, rate, gain and comparator fields.
// - the setup register answers at pointer one and resets to 8583h.
// - bit 15 reads as conversion status and writes as single-shot start.
// - writing 1 to bit 15 while powered down runs one conversion, writing 0 does nothing.
// - writes to bit 15 during a conversion neither restart nor abort it.
// - bit 15 reads 0 while converting and 1 otherwise, and resets to 1.
// - bits 14:12 choose the input pair, resetting to 000.
// - bits 11:9 choose the full-scale span, resetting to 010.
// - bit 8 at 0 runs continuously, at 1 single-shot with power-down, resetting to 1.
// - bits 7:5 pick 8 to 860 samples per second, resetting to 128.
// - the last written 2-bit pointer selects which register is accessed.
// - the result register holds the latest two's complement value and reads 0 until the first one.
// - register words travel as two bytes, most significant first, both ways.
module adcr_top
  import adcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int unsigned CLK_HZ = ADCR_SYS_CLK_HZ
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] sample_i,
  output logic [2:0] input_pair_select_o,
  output logic [2:0] gain_range_select_o,
  output logic [2:0] sample_rate_select_o,
  output logic continuous_mode_o,
  output logic converting_o
);
  adcr_state_t s_ff;
  adcr_state_t nxt_s;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;

  // the bus clock is only sampled, never used as a clock
  adcr_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  function automatic logic [31:0] rate_cycles(input logic [2:0] sel);
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < ADCR_RATES; i++) begin
      if (sel == 3'(i)) begin
        r = 32'(CLK_HZ / ADCR_SPS[i]);
      end
    end
    if (r == 32'h0) begin
      r = 32'h1;
    end
    return r;
  endfunction : rate_cycles

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic busy;
  logic wr_setup;
  logic [15:0] wr_val;
  logic [15:0] rd_word;
  logic [15:0] word;
  logic start_conv;
  logic [2:0] rate_sel;

  always_comb begin
    nxt_s = s_ff;
    scl_rise = scl_s & ~s_ff.scl_q;
    scl_fall = ~scl_s & s_ff.scl_q;
    bus_start = scl_s & s_ff.scl_q & s_ff.sda_q & ~sda_s;
    bus_stop = scl_s & s_ff.scl_q & ~s_ff.sda_q & sda_s;
    busy = (s_ff.cst == C_RUN);
    wr_setup = 1'b0;
    wr_val = 16'h0000;
    word = 16'h0000;
    nxt_s.scl_q = scl_s;
    nxt_s.sda_q = sda_s;
    unique case (s_ff.ptr)
      ADCR_PTR_RESULT: rd_word = s_ff.result;
      ADCR_PTR_SETUP: rd_word = {~busy, s_ff.setup};
      ADCR_PTR_LO_THR: rd_word = ADCR_UNMAPPED_READ;
      ADCR_PTR_HI_THR: rd_word = ADCR_UNMAPPED_READ;
    endcase

    if (bus_start) begin
      nxt_s.ist = I_ADDR;
      nxt_s.bit_cnt = 3'h0;
      nxt_s.got_byte = 1'b0;
      nxt_s.pull = 1'b0;
      nxt_s.second = 1'b0;
    end else if (bus_stop) begin
      nxt_s.ist = I_IDLE;
      nxt_s.pull = 1'b0;
    end else begin
      unique case (s_ff.ist)
        I_IDLE: begin
          nxt_s.pull = 1'b0;
        end
        I_ADDR, I_PTR, I_WDATA: begin
          if (scl_rise) begin
            nxt_s.shift = {s_ff.shift[6:0], sda_s};
            nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
            nxt_s.got_byte = (s_ff.bit_cnt == ADCR_LAST_BIT);
          end else if (scl_fall && s_ff.got_byte) begin
            nxt_s.got_byte = 1'b0;
            nxt_s.pull = 1'b1;
            if (s_ff.ist == I_ADDR) begin
              nxt_s.rw = s_ff.shift[0];
              nxt_s.ist = I_AACK;
              if (s_ff.shift[7:1] != DEV_ADDR) begin
                nxt_s.pull = 1'b0;
                nxt_s.ist = I_IDLE;
              end
            end else if (s_ff.ist == I_PTR) begin
              nxt_s.ptr = s_ff.shift[1:0];
              nxt_s.ist = I_PACK;
            end else begin
              nxt_s.ist = I_WACK;
              nxt_s.second = ~s_ff.second;
              if (!s_ff.second) begin
                nxt_s.hold = s_ff.shift;
              end else if (s_ff.ptr == ADCR_PTR_SETUP) begin
                wr_setup = 1'b1;
                wr_val = {s_ff.hold, s_ff.shift};
              end
            end
          end
        end
        I_AACK: begin
          if (scl_fall) begin
            nxt_s.bit_cnt = 3'h0;
            if (s_ff.rw) begin
              // whole word caught at once so both bytes agree
              word = rd_word;
              nxt_s.shift = word[15:8];
              nxt_s.tx_lo = word[7:0];
              nxt_s.second = 1'b1;
              nxt_s.pull = ~word[15];
              nxt_s.ist = I_RDATA;
            end else begin
              nxt_s.pull = 1'b0;
              nxt_s.ist = I_PTR;
            end
          end
        end
        I_PACK, I_WACK: begin
          if (scl_fall) begin
            nxt_s.pull = 1'b0;
            nxt_s.bit_cnt = 3'h0;
            nxt_s.ist = I_WDATA;
          end
        end
        I_RDATA: begin
          if (scl_fall) begin
            nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
            if (s_ff.bit_cnt == ADCR_LAST_BIT) begin
              nxt_s.pull = 1'b0;
              nxt_s.ist = I_RACK;
            end else begin
              nxt_s.shift = {s_ff.shift[6:0], 1'b0};
              nxt_s.pull = ~s_ff.shift[6];
            end
          end
        end
        I_RACK: begin
          if (scl_rise && sda_s) begin
            nxt_s.ist = I_IDLE;
          end else if (scl_fall) begin
            // further bytes wrap to a fresh word, high byte again
            word = s_ff.second ? {s_ff.tx_lo, 8'h00} : rd_word;
            nxt_s.shift = word[15:8];
            if (!s_ff.second) begin
              nxt_s.tx_lo = word[7:0];
            end
            nxt_s.second = ~s_ff.second;
            nxt_s.pull = ~word[15];
            nxt_s.bit_cnt = 3'h0;
            nxt_s.ist = I_RDATA;
          end
        end
        default: begin
          nxt_s.pull = 1'b0;
          nxt_s.ist = I_IDLE;
        end
      endcase
    end

    if (wr_setup) begin
      nxt_s.setup = wr_val[14:0];
    end
    rate_sel = wr_setup ? wr_val[ADCR_RATE_HI:ADCR_RATE_LO]
                        : s_ff.setup[ADCR_RATE_HI:ADCR_RATE_LO];
    // start bit only counts when idle; a 0 write is a no-op
    start_conv = ~busy & ((wr_setup & wr_val[ADCR_START_BIT])
                 | (nxt_s.setup[ADCR_MODE_BIT] == ADCR_MODE_CONT));

    unique case (s_ff.cst)
      C_IDLE: begin
        if (start_conv) begin
          nxt_s.cst = C_RUN;
          nxt_s.cyc = 32'h0;
          nxt_s.period = rate_cycles(rate_sel);
        end
      end
      C_RUN: begin
        // rate is fixed per conversion; a change applies to the next
        if (s_ff.cyc >= s_ff.period - 32'h1) begin
          nxt_s.result = sample_i;
          nxt_s.cyc = 32'h0;
          if (nxt_s.setup[ADCR_MODE_BIT] == ADCR_MODE_CONT) begin
            nxt_s.period = rate_cycles(
              nxt_s.setup[ADCR_RATE_HI:ADCR_RATE_LO]);
          end else begin
            nxt_s.cst = C_IDLE;
          end
        end else begin
          nxt_s.cyc = s_ff.cyc + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= '0;
      s_ff.scl_q <= 1'b1;
      s_ff.sda_q <= 1'b1;
      s_ff.ist <= I_IDLE;
      s_ff.ptr <= ADCR_PTR_RESULT;
      s_ff.setup <= ADCR_SETUP_RESET[14:0];
      s_ff.result <= ADCR_RESULT_RESET;
      s_ff.cst <= C_IDLE;
      s_ff.period <= 32'h1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = s_ff.pull;
  assign input_pair_select_o = s_ff.setup[ADCR_PAIR_HI:ADCR_PAIR_LO];
  assign gain_range_select_o = s_ff.setup[ADCR_GAIN_HI:ADCR_GAIN_LO];
  assign sample_rate_select_o = s_ff.setup[ADCR_RATE_HI:ADCR_RATE_LO];
  assign continuous_mode_o = (s_ff.setup[ADCR_MODE_BIT] == ADCR_MODE_CONT);
  assign converting_o = busy;
endmodule : adcr_top

// ---- include/adcr_pkg.sv ----
package adcr_pkg;
  localparam int unsigned ADCR_SYS_CLK_HZ = 200_000_000;
  localparam int unsigned ADCR_RATES = 8;
  localparam int unsigned ADCR_SPS [ADCR_RATES] = '{
    8, 16, 32, 64, 128, 250, 475, 860
  };

  localparam logic [1:0] ADCR_PTR_RESULT = 2'h0;
  localparam logic [1:0] ADCR_PTR_SETUP = 2'h1;
  localparam logic [1:0] ADCR_PTR_LO_THR = 2'h2;
  localparam logic [1:0] ADCR_PTR_HI_THR = 2'h3;

  localparam logic [15:0] ADCR_SETUP_RESET = 16'h8583;
  localparam logic [15:0] ADCR_RESULT_RESET = 16'h0000;
  localparam logic [15:0] ADCR_UNMAPPED_READ = 16'h0000;

  localparam int ADCR_START_BIT = 15;
  localparam int ADCR_PAIR_HI = 14;
  localparam int ADCR_PAIR_LO = 12;
  localparam int ADCR_GAIN_HI = 11;
  localparam int ADCR_GAIN_LO = 9;
  localparam int ADCR_MODE_BIT = 8;
  localparam int ADCR_RATE_HI = 7;
  localparam int ADCR_RATE_LO = 5;
  localparam logic ADCR_MODE_CONT = 1'b0;

  localparam logic [2:0] ADCR_LAST_BIT = 3'h7;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_AACK = 4'b0010,
    I_PTR = 4'b0011,
    I_PACK = 4'b0100,
    I_WDATA = 4'b0101,
    I_WACK = 4'b0110,
    I_RDATA = 4'b0111,
    I_RACK = 4'b1000
  } adcr_i2c_st_t;

  typedef enum logic {
    C_IDLE = 1'b0,
    C_RUN = 1'b1
  } adcr_cv_st_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    adcr_i2c_st_t ist;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic got_byte;
    logic rw;
    logic [1:0] ptr;
    logic [7:0] hold;
    logic second;
    logic [7:0] tx_lo;
    logic pull;
    logic [14:0] setup;
    logic [15:0] result;
    adcr_cv_st_t cst;
    logic [31:0] cyc;
    logic [31:0] period;
  } adcr_state_t;
endpackage : adcr_pkg

// ---- hdl/adcr_sync2.sv ----
`timescale 1ns/1ps
module adcr_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } adcr_sync_t;

  adcr_sync_t s_ff;
  adcr_sync_t nxt_s;

  // idle bus level is high, so reset to ones avoids a false start
  always_comb begin
    nxt_s.meta = async_i;
    nxt_s.out = s_ff.meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sync_o = s_ff.out;
endmodule : adcr_sync2

// ---- tb/adcr_top_checker.sv ----
`timescale 1ns/1ps
module adcr_top_checker #(
  parameter int unsigned CLK_HZ = 200_000_000
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [15:0] sample_i,
  input wire logic [2:0] input_pair_select_o,
  input wire logic [2:0] gain_range_select_o,
  input wire logic [2:0] sample_rate_select_o,
  input wire logic continuous_mode_o,
  input wire logic converting_o
);
  // slowest rate bounds one shot; a restart would overrun it
  localparam int MAX_RUN = CLK_HZ / 8 + 2;
  logic [31:0] run_ff;
  logic [31:0] nxt_run;
  always_comb begin
    nxt_run = (converting_o && !continuous_mode_o) ? run_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk_i) begin
    run_ff <= srst_i ? 32'h0 : nxt_run;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  a_sda_held_low: assert property (sda_o == 1'b0)
    else $error("sda data value not low");
  a_ack_scl_low: assert property (
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("sda driver moved while scl high");
  a_reset_values: assert property (
    $past(srst_i) |-> input_pair_select_o == 3'h0 && !sda_oe_o
    && gain_range_select_o == 3'h2 && sample_rate_select_o == 3'h4
    && !continuous_mode_o && !converting_o)
    else $error("outputs not at reset values");
  a_single_fall: assert property (
    $fell(converting_o) |-> !continuous_mode_o)
    else $error("conversion stopped in continuous mode");
  a_single_run: assert property (run_ff <= MAX_RUN)
    else $error("single conversion ran too long");
  a_cont_runs: assert property (
    continuous_mode_o |-> ##[0:2] converting_o)
    else $error("continuous mode not converting");
  a_start_commit: assert property (
    $rose(converting_o) |-> !$past(scl_i, 2))
    else $error("conversion began outside a commit");
  a_setup_commit: assert property (
    $changed({input_pair_select_o, gain_range_select_o,
    sample_rate_select_o, continuous_mode_o}) |-> !$past(scl_i, 2))
    else $error("setup changed outside a commit");
endmodule : adcr_top_checker
bind adcr_top adcr_top_checker #(.CLK_HZ(CLK_HZ)) adcr_top_checker_inst (
  .sys_clk_i, .srst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .sample_i,
  .input_pair_select_o, .gain_range_select_o, .sample_rate_select_o,
  .continuous_mode_o, .converting_o
);

// ---- tb/adcr_i2c_master.sv ----
`timescale 1ns/1ps
module adcr_i2c_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic put(input logic b);
    sda_low_o = ~b;
    #12 scl_o = 1'b1;
    #24 scl_o = 1'b0;
    #12;
  endtask : put
  task automatic get(output logic b);
    sda_low_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 b = sda_i;
    #12 scl_o = 1'b0;
    #12;
  endtask : get
  task automatic send(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(a);
    ok = ok & ~a;
  endtask : send
  task automatic wr(input logic [6:0] a, input logic [1:0] p,
                    input logic [15:0] d, input logic two, output logic ok);
    ok = 1'b1;
    sda_low_o = 1'b1;
    #24 scl_o = 1'b0;
    #12 send({a, 1'b0}, ok);
    send({6'h00, p}, ok);
    if (two) begin
      send(d[15:8], ok);
      send(d[7:0], ok);
    end
    sda_low_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_low_o = 1'b0;
    #48;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d,
                    output logic ok);
    logic b;
    ok = 1'b1;
    sda_low_o = 1'b1;
    #24 scl_o = 1'b0;
    #12 send({a, 1'b1}, ok);
    for (int i = 15; i >= 0; i--) begin
      get(b);
      d[i] = b;
      if (i == 8) put(1'b0);
    end
    put(1'b1);
    sda_low_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_low_o = 1'b0;
    #48;
  endtask : rd
endmodule : adcr_i2c_master

// ---- tb/adcr_top_tb_top.sv ----
`timescale 1ns/1ps
module adcr_top_tb_top;
  import adcr_pkg::*;
  localparam logic [6:0] ADR = 7'h2a;
  logic sys_clk_i, srst_i, scl_i, sda_low, sda_o, sda_oe_o, ok;
  logic continuous_mode_o, converting_o;
  logic [2:0] input_pair_select_o, gain_range_select_o;
  logic [2:0] sample_rate_select_o, v;
  logic [15:0] sample_i, d, outs;
  wire sda_i;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // open-drain wire with pull-up
  assign sda_i = !(sda_low || (sda_oe_o && !sda_o));
  assign outs = {5'h0, input_pair_select_o, gain_range_select_o,
                 sample_rate_select_o, continuous_mode_o, converting_o};
  adcr_top #(.DEV_ADDR(ADR), .CLK_HZ(8600)) adcr_top_inst (
    .sys_clk_i, .srst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .sample_i,
    .input_pair_select_o, .gain_range_select_o, .sample_rate_select_o,
    .continuous_mode_o, .converting_o
  );
  adcr_i2c_master mst (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i(sda_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic give_verdict;
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wset(input logic [15:0] w);
    mst.wr(ADR, ADCR_PTR_SETUP, w, 1'b1, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask : wset
  task automatic rreg(input logic [1:0] p, input logic [15:0] exp);
    mst.wr(ADR, p, 16'h0000, 1'b0, ok);
    mst.rd(ADR, d, ok);
    chk(d, exp);
  endtask : rreg
  task automatic idle;
    for (int i = 0; i < 3000 && converting_o !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask : idle
  initial begin
    srst_i = 1'b1;
    sample_i = 16'h0000;
    repeat (20) @(posedge sys_clk_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk(outs, 16'h0050);
    rreg(ADCR_PTR_RESULT, 16'h0000);
    rreg(ADCR_PTR_SETUP, 16'h8583);
    mst.rd(ADR, d, ok);
    chk(d, 16'h8583);
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wset({1'b0, v, v, 1'b1, v, 5'h03});
      chk(outs, {5'h0, v, v, v, 2'b00});
    end
    @(posedge sys_clk_i);
    #1 sample_i = 16'h8123;
    wset(16'hbb03);
    chk(outs, 16'h03a1);
    rreg(ADCR_PTR_SETUP, 16'h3b03);
    wset(16'hbd03);
    chk(outs, 16'h03c1);
    idle();
    rreg(ADCR_PTR_RESULT, 16'h8123);
    rreg(ADCR_PTR_SETUP, 16'hbd03);
    wset(16'h3ce3);
    chk(outs, 16'h03df);
    @(posedge sys_clk_i);
    #1 sample_i = 16'h0042;
    repeat (30) @(posedge sys_clk_i);
    rreg(ADCR_PTR_RESULT, 16'h0042);
    wset(16'h3de3);
    idle();
    chk(outs, 16'h03dc);
    mst.wr(ADR, ADCR_PTR_HI_THR, 16'h1234, 1'b1, ok);
    chk({15'h0, ok}, 16'h0001);
    mst.rd(ADR, d, ok);
    chk(d, 16'h0000);
    rreg(ADCR_PTR_LO_THR, 16'h0000);
    mst.wr(7'h2b, ADCR_PTR_SETUP, 16'h8000, 1'b1, ok);
    chk({15'h0, ok}, 16'h0000);
    chk(outs, 16'h03dc);
    give_verdict();
  end
endmodule : adcr_top_tb_top
